// ===== hw/dzg_cal_core.sv
// Per-channel user zero and gain calibration: eight trim registers and the
// digital correction of four 14-bit channel codes.
// Output carries 14 integer and 5 fraction bits, signed when bipolar.
// Assumes the serial frame decoder presents single-cycle register requests
// on mclk, and channel codes come from logic on the same clock.
`timescale 1ns/1ps
`include "dzg_defines.svh"

module dzg_cal_core #(
  parameter int NUM_CH = 4
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire dzg_pkg::dzg_req_t reg_req,
  output logic [`DZG_REG_W-1:0] reg_rdata,
  input wire logic [NUM_CH-1:0][`DZG_CODE_W-1:0] channel_code,
  input wire logic [NUM_CH-1:0] bipolar_mode,
  output logic [NUM_CH-1:0][`DZG_OUT_W-1:0] cal_code
);
  import dzg_pkg::*;

  // Index decode covers exactly four channels per register kind
  if (NUM_CH != 4) begin : g_num_ch_check
    $error("dzg_cal_core serves exactly four channels");
  end

  // Corrected code in 1/32 LSB units: 14 integer bits, 5 fraction bits
  function automatic logic [`DZG_OUT_W-1:0] dzg_apply(
    input logic [`DZG_CODE_W-1:0] code,
    input logic bip,
    input dzg_cal_t cal
  );
    logic signed [23:0] base;
    logic signed [23:0] slope;
    logic signed [23:0] prod;
    logic signed [23:0] sum;
    logic [`DZG_OUT_W-1:0] res;
    base = bip ? {{10{code[13]}}, code} : {10'h000, code};
    slope = {{16{cal.slope_trim_field[7]}}, cal.slope_trim_field};
    // Product fits 24 bits: 14-bit code times 8-bit trim, no overflow
    prod = base * slope;
    // Slope acts on the full-scale span, so it pivots about code zero
    prod = bip ? (prod >>> `DZG_BIP_SHIFT) : (prod >>> `DZG_UNI_SHIFT);
    sum = (base <<< `DZG_FRAC_W) + prod
      + {{15{cal.offset_trim_field[8]}}, cal.offset_trim_field};
    if (bip) begin
      if (sum > $signed(`DZG_BIP_MAX)) begin
        res = `DZG_SAT_BIP_HI;
      end else if (sum < $signed(`DZG_BIP_MIN)) begin
        res = `DZG_SAT_BIP_LO;
      end else begin
        res = sum[`DZG_OUT_W-1:0];
      end
    end else begin
      if (sum < 0) begin
        res = `DZG_SAT_UNI_LO;
      end else if (sum > $signed(`DZG_UNI_MAX)) begin
        res = `DZG_SAT_UNI_HI;
      end else begin
        res = sum[`DZG_OUT_W-1:0];
      end
    end
    return res;
  endfunction

  // Trim state, read latch and output pipeline
  dzg_cal_t [NUM_CH-1:0] cal_r;
  dzg_cal_t [NUM_CH-1:0] cal_nxt;
  logic [`DZG_REG_W-1:0] rdata_r;
  logic [`DZG_REG_W-1:0] rdata_nxt;
  logic [NUM_CH-1:0][`DZG_OUT_W-1:0] out_r;
  logic [NUM_CH-1:0][`DZG_OUT_W-1:0] out_nxt;
  logic [1:0] ch_sel;
  logic is_gain;

  // Index bit 2 picks gain over zero; bits 1:0 pick the channel
  assign ch_sel = reg_req.addr[1:0];
  assign is_gain = reg_req.addr[`DZG_ADDR_GAIN_BIT];

  // Register writes; reserved bits are dropped, so they cannot be stored
  always_comb begin
    cal_nxt = cal_r;
    if (reg_req.wr_en) begin
      if (is_gain) begin
        cal_nxt[ch_sel].slope_trim_field = reg_req.wdata[`DZG_SLOPE_W-1:0];
      end else begin
        cal_nxt[ch_sel].offset_trim_field = reg_req.wdata[`DZG_OFFSET_W-1:0];
      end
    end
  end

  // Read data holds until the next read
  always_comb begin
    rdata_nxt = rdata_r;
    if (reg_req.rd_en) begin
      if (is_gain) begin
        rdata_nxt = {8'h00, cal_r[ch_sel].slope_trim_field};
      end else begin
        rdata_nxt = {7'h00, cal_r[ch_sel].offset_trim_field};
      end
    end
  end

  // One pipeline stage keeps the multiplier off the output pins
  always_comb begin
    for (int i = 0; i < NUM_CH; i++) begin
      out_nxt[i] = dzg_apply(channel_code[i], bipolar_mode[i], cal_r[i]);
    end
  end

  // Synchronous reset clears trims, read latch and output pipeline
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      for (int i = 0; i < NUM_CH; i++) begin
        cal_r[i].offset_trim_field <= `DZG_OFFSET_RST;
        cal_r[i].slope_trim_field <= `DZG_SLOPE_RST;
        out_r[i] <= '0;
      end
      rdata_r <= '0;
    end else begin
      cal_r <= cal_nxt;
      rdata_r <= rdata_nxt;
      out_r <= out_nxt;
    end
  end

  assign reg_rdata = rdata_r;
  assign cal_code = out_r;

  // Reset and register file checks
  a_reset_outputs: assert property (@(posedge mclk)
    $past(sys_rst) |-> rdata_r == 16'h0000 && out_r[0] == 19'h0_0000
      && out_r[3] == 19'h0_0000)
    else $error("read latch or output not cleared by reset");

  a_zero_reset: assert property (@(posedge mclk)
    $past(sys_rst) |-> cal_r[0].offset_trim_field == 9'h000
      && cal_r[3].offset_trim_field == 9'h000)
    else $error("zero trim not cleared by reset");

  a_gain_reset: assert property (@(posedge mclk)
    $past(sys_rst) |-> cal_r[1].slope_trim_field == 8'h00
      && cal_r[2].slope_trim_field == 8'h00)
    else $error("gain trim not cleared by reset");

  a_zero_write: assert property (@(posedge mclk) disable iff (sys_rst)
    reg_req.wr_en && !is_gain |=> cal_r[$past(ch_sel)].offset_trim_field
      == $past(reg_req.wdata[8:0]))
    else $error("zero register write not stored");

  a_gain_write: assert property (@(posedge mclk) disable iff (sys_rst)
    reg_req.wr_en && is_gain |=> cal_r[$past(ch_sel)].slope_trim_field
      == $past(reg_req.wdata[7:0]))
    else $error("gain register write not stored");

  a_zero_readback: assert property (@(posedge mclk) disable iff (sys_rst)
    reg_req.rd_en && !is_gain |=> rdata_r[15:9] == 7'h00)
    else $error("zero register reserved bits not zero");

  a_zero_value: assert property (@(posedge mclk) disable iff (sys_rst)
    reg_req.rd_en && !is_gain |=> rdata_r[8:0]
      == $past(cal_r[ch_sel].offset_trim_field))
    else $error("zero register readback wrong");

  a_gain_readback: assert property (@(posedge mclk) disable iff (sys_rst)
    reg_req.rd_en && is_gain |=> rdata_r[15:8] == 8'h00
      && rdata_r[7:0] == $past(cal_r[ch_sel].slope_trim_field))
    else $error("gain register readback wrong");

  a_chan_isolate: assert property (@(posedge mclk) disable iff (sys_rst)
    reg_req.wr_en && ch_sel != 2'd0 |=> $stable(cal_r[0]))
    else $error("write leaked into channel 0 trims");

  a_last_isolate: assert property (@(posedge mclk) disable iff (sys_rst)
    reg_req.wr_en && ch_sel != 2'd3 |=> $stable(cal_r[3]))
    else $error("write leaked into channel 3 trims");

  // Datapath checks; the bench drives the corner codes they need
  a_null_trim: assert property (@(posedge mclk) disable iff (sys_rst)
    cal_r[0] == '0 && !bipolar_mode[0] && $stable(cal_r[0])
      |=> out_r[0] == {$past(channel_code[0]), 5'h00})
    else $error("zero trims altered the code");

  a_offset_shift: assert property (@(posedge mclk) disable iff (sys_rst)
    cal_r[1].slope_trim_field == 8'h00 && bipolar_mode[1] && channel_code[1] == 14'h0000
      |=> out_r[1] == {{10{$past(cal_r[1].offset_trim_field[8])}},
        $past(cal_r[1].offset_trim_field)})
    else $error("offset not applied as constant shift");

  // With a non-negative slope, an offset of a full LSB or more lifts the top code past the ceiling
  a_uni_ceiling: assert property (@(posedge mclk) disable iff (sys_rst)
    !bipolar_mode[2] && channel_code[2] == 14'h3fff && !cal_r[2].slope_trim_field[7]
      && !cal_r[2].offset_trim_field[8] && cal_r[2].offset_trim_field[7:5] != 3'h0
      |=> out_r[2] == 19'h7_ffff)
    else $error("unipolar output did not saturate high");

  a_uni_floor: assert property (@(posedge mclk) disable iff (sys_rst)
    !bipolar_mode[1] && channel_code[1] == 14'h0000 && cal_r[1].offset_trim_field[8]
      |=> out_r[1] == 19'h0_0000)
    else $error("unipolar output did not saturate low");

  a_bip_floor: assert property (@(posedge mclk) disable iff (sys_rst)
    bipolar_mode[3] && channel_code[3] == 14'h2000 && !cal_r[3].slope_trim_field[7]
      && cal_r[3].offset_trim_field[8]
      |=> out_r[3] == 19'h4_0000)
    else $error("bipolar output did not saturate low");
endmodule

// ===== hw/dzg_defines.svh
// Offsets, field layouts, reset values and arithmetic constants for the
// zero/gain calibration block. Included by the package and the design.
`ifndef DZG_DEFINES_SVH
`define DZG_DEFINES_SVH

// Register index on the decoded register port (3-bit index)
`define DZG_ADDR_W 3
`define DZG_ADDR_ZERO_BASE 3'h0
`define DZG_ADDR_GAIN_BASE 3'h4
`define DZG_ADDR_GAIN_BIT 2

// Field layout
`define DZG_REG_W 16
`define DZG_OFFSET_W 9
`define DZG_SLOPE_W 8
`define DZG_CODE_W 14
`define DZG_FRAC_W 5
`define DZG_OUT_W 19
`define DZG_OFFSET_RST 9'h000
`define DZG_SLOPE_RST 8'h00

// Arithmetic: slope step 1/4 LSB at full scale, expressed in 1/32 LSB
`define DZG_BIP_SHIFT 10
`define DZG_UNI_SHIFT 11
`define DZG_BIP_MAX 24'h03_ffff
`define DZG_BIP_MIN 24'hfc_0000
`define DZG_UNI_MAX 24'h07_ffff
`define DZG_SAT_BIP_HI 19'h3_ffff
`define DZG_SAT_BIP_LO 19'h4_0000
`define DZG_SAT_UNI_HI 19'h7_ffff
`define DZG_SAT_UNI_LO 19'h0_0000

`endif

// ===== hw/dzg_pkg.sv
// Types shared by the zero/gain calibration block.
// Assumes dzg_defines.svh sits on the include path.
`include "dzg_defines.svh"

package dzg_pkg;
  // One channel's calibration pair
  typedef struct packed {
    logic [`DZG_OFFSET_W-1:0] offset_trim_field;
    logic [`DZG_SLOPE_W-1:0] slope_trim_field;
  } dzg_cal_t;

  // Register write/read request from the decoded serial frame
  typedef struct packed {
    logic wr_en;
    logic rd_en;
    logic [`DZG_ADDR_W-1:0] addr;
    logic [`DZG_REG_W-1:0] wdata;
  } dzg_req_t;
endpackage

// ===== test/dzg_host.sv
// Host model for the calibration block: one-cycle register requests.
// Assumes dzg_pkg is compiled first and the bench calls its tasks.
`timescale 1ns/1ps
module dzg_host (
  input wire logic mclk,
  output dzg_pkg::dzg_req_t req
);
  import dzg_pkg::*;
  initial req = '0;
  // Pulse taken at the next edge; idle lines show the inverse, never the old word
  task automatic xfer(input logic w, input logic [2:0] a, input logic [15:0] d);
    @(posedge mclk) #1;
    req = '{wr_en: w, rd_en: !w, addr: a, wdata: d};
    @(posedge mclk) #1;
    req = '{wr_en: 1'b0, rd_en: 1'b0, addr: ~a, wdata: ~d};
  endtask
  // Trim count: negated error over step size, twos complement
  function automatic logic [15:0] steps(input int err, input int step);
    int q;
    q = -err;
    // Rounded to the nearest step, away from zero on a tie
    return 16'((q < 0 ? q - step / 2 : q + step / 2) / step);
  endfunction
endmodule

// ===== test/testbench.sv
// Self-checking bench for the zero/gain calibration block.
// Assumes dzg_pkg and the host model are compiled before it.
`timescale 1ns/1ps
module testbench;
  import dzg_pkg::*;
  logic mclk = 0;
  logic sys_rst = 1;
  dzg_req_t req;
  logic [15:0] rdata;
  logic [3:0][13:0] code = '0;
  logic [3:0] bip = '0;
  logic [3:0][18:0] cal;
  logic [8:0] zs [4];
  logic [7:0] gs [4];
  logic [31:0] r;
  logic [15:0] wval;
  int mismatches = 0;
  int num_checks = 0;
  int cyc = 0;
  integer seed = 32'hbf84;
  // 25 MHz clock
  always #20 mclk = ~mclk;
  dzg_host i_host (.mclk(mclk), .req(req));
  dzg_cal_core i_dut (.mclk(mclk), .sys_rst(sys_rst), .reg_req(req), .reg_rdata(rdata),
    .channel_code(code), .bipolar_mode(bip), .cal_code(cal));
  // Compare and count
  task automatic check(input logic [18:0] seen, input logic [18:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic finish_test;
    $display("checks=%0d mismatches=%0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // Hang guard, well above the roughly one thousand cycles needed
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      finish_test();
    end
  end
  // Slope pivots on code zero; floor of slope term, then saturate
  function automatic logic [18:0] expc(input logic [13:0] c, input logic b,
      input logic [8:0] z, input logic [7:0] g);
    longint x;
    longint s;
    x = b ? longint'($signed(c)) : longint'(c);
    s = x * 32 + ((x * longint'($signed(g))) >>> (b ? 10 : 11)) + longint'($signed(z));
    if (b)
      s = s > 262143 ? 262143 : (s < -262144 ? -262144 : s);
    else
      s = s > 524287 ? 524287 : (s < 0 ? 0 : s);
    return s[18:0];
  endfunction
  task automatic rd(input logic [2:0] a, input logic [15:0] exp);
    i_host.xfer(1'b0, a, 16'h0000);
    check(19'(rdata), 19'(exp));
  endtask
  // Write, keeping a shadow of the trims that survive
  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    i_host.xfer(1'b1, a, d);
    if (a[2])
      gs[a[1:0]] = d[7:0];
    else
      zs[a[1:0]] = d[8:0];
  endtask
  // Main sequence
  initial begin
    repeat (2) @(posedge mclk);
    #1 sys_rst = 0;
    for (int i = 0; i < 8; i++) rd(3'(i), 16'h0000);
    wr(3'h1, i_host.steps(-1000, 38));
    rd(3'h1, 16'h001a);
    wr(3'h1, i_host.steps(1000, 38));
    rd(3'h1, 16'h01e6);
    wr(3'h6, i_host.steps(10000, 305));
    rd(3'h6, 16'h00df);
    wr(3'h6, i_host.steps(-10000, 305));
    rd(3'h6, 16'h0021);
    for (int n = 0; n < 400; n++) begin
      // Trims: random words, field minimums, maximums, all zero, zero slope
      if (n % 25 == 0) begin
        for (int i = 0; i < 8; i++) begin
          r = $random(seed);
          case (n)
            25: wval = i[2] ? 16'hff80 : 16'hff00;
            50: wval = i[2] ? 16'h007f : 16'h00ff;
            75: wval = 16'h0000;
            100: wval = i[2] ? 16'h0000 : (r[15:0] | 16'h0100);
            default: wval = r[15:0];
          endcase
          wr(3'(i), wval);
          rd(3'(i), i[2] ? 16'(gs[i[1:0]]) : 16'(zs[i[1:0]]));
        end
      end
      // Codes: random, every third pass the range ends
      for (int c = 0; c < 4; c++) begin
        r = $random(seed);
        code[c] = n % 3 == 0 ? {r[1], {13{r[0]}}} : r[13:0];
        bip[c] = r[20];
        // Corners: zero input bipolar, unipolar full scale, bipolar negative end
        if (n % 4 == 1) begin
          code[c] = 14'h0000;
          bip[c] = 1'b1;
        end else if (n % 4 == 3) begin
          code[c] = n % 8 == 3 ? 14'h3fff : 14'h2000;
          bip[c] = n % 8 == 7;
        end
      end
      @(posedge mclk) #1;
      for (int c = 0; c < 4; c++)
        check(cal[c], expc(code[c], bip[c], zs[c], gs[c]));
    end
    // Mid-run reset: trims, read latch and outputs go back to zero
    sys_rst = 1;
    repeat (2) @(posedge mclk);
    #1;
    for (int c = 0; c < 4; c++) check(cal[c], 19'h0_0000);
    sys_rst = 0;
    check(19'(rdata), 19'h0_0000);
    for (int i = 0; i < 4; i++) begin
      zs[i] = 9'h000;
      gs[i] = 8'h00;
    end
    for (int i = 0; i < 8; i++) rd(3'(i), 16'h0000);
    for (int c = 0; c < 4; c++)
      check(cal[c], expc(code[c], bip[c], zs[c], gs[c]));
    finish_test();
  end
endmodule
